// ===== rtl/mcr_bank.v
// control register bank of an analog monitor, reached over a two-wire
// serial bus (clock line in, open-drain data line) sampled by clock.
// assumes the bus clock is well below a quarter of the core clock.
`timescale 1ns/10ps
`include "mcr_regs.vh"

module mcr_bank #(
	parameter [6:0] DEV_ADDR = 7'h40, // arbitrary bus address
	parameter       MON      = `MCR_MON_CHANNELS,
	parameter       RW       = `MCR_RESULT_BITS
) (
	// clock and reset
	input  wire            clock,
	input  wire            srst,
	// serial bus pins
	input  wire            scl_in,
	input  wire            sda_in,
	output wire            sda_out,
	output wire            sda_oe,
	// conversion results from the sequencer (same clock)
	input  wire            result_valid,
	input  wire [2:0]      result_sel,
	input  wire [RW-1:0]   result_data,
	input  wire [MON*RW-1:0] upper_threshold,
	input  wire [MON*RW-1:0] lower_threshold,
	// sequencer control
	output wire            continuous_run,
	output reg             oneshot_fire,
	output wire [16:0]     input_include,
	output wire            bus_timeout_disable,
	output wire            register_lock,
	// dac and gpio control
	output wire            output_grouping_select,
	output wire            forced_rail_select,
	output wire            analog_outputs_hiz,
	output wire [7:0]      pulldown_off,
	// interrupt lines
	output wire            limit_irq_line_a,
	output wire            limit_irq_line_b
);

	// ---------------------------------------------------------------
	// bus engine states and phases
	// ---------------------------------------------------------------
	localparam [2:0] ST_IDLE = 3'd0;
	localparam [2:0] ST_RX   = 3'd1;
	localparam [2:0] ST_ACK  = 3'd2;
	localparam [2:0] ST_TX   = 3'd3;
	localparam [2:0] ST_RACK = 3'd4;
	localparam [1:0] PH_ADDR = 2'd0;
	localparam [1:0] PH_PTR  = 2'd1;
	localparam [1:0] PH_DATA = 2'd2;
	reg  [2:0] state_q;
	reg  [1:0] phase_q;
	reg  [3:0] bit_cnt_q;
	reg  [7:0] shift_q, ptr_q, wr_ptr_q, wr_data_q;
	reg        read_q, sda_oe_q, scl_d_q, sda_d_q, wr_q;
	// registers
	reg  [7:0] general_config_q, dac_output_config_q;
	reg  [7:0] gpio_pulldown_control_q, high_limit_irq_enable_q;
	reg  [7:0] low_limit_irq_enable_q, channel_enable_low_q;
	reg  [7:0] channel_enable_high_q, temp_channel_enable_q;
	reg  [MON-1:0] over_limit_status_q, under_limit_status_q;
	// bus events and decodes
	wire       scl_s, sda_s, scl_rise, scl_fall;
	wire       bus_start, bus_stop, lockable, soft_reset;
	reg  [7:0] rd_data;

	// ---------------------------------------------------------------
	// pin synchronisers and bus events
	// ---------------------------------------------------------------
	mcr_sync #(
		.WIDTH    (2)
	) u_sync (
		.clock    (clock),
		.srst     (srst),
		.async_in ({scl_in, sda_in}),
		.sync_out ({scl_s, sda_s})
	);

	// one more stage to find edges; reset to the idle high bus level
	always @(posedge clock) begin
		scl_d_q <= scl_s | srst;
		sda_d_q <= sda_s | srst;
	end

	assign scl_rise  = scl_s & ~scl_d_q;
	assign scl_fall  = ~scl_s & scl_d_q;
	assign bus_start = scl_s & scl_d_q & sda_d_q & ~sda_s;
	assign bus_stop  = scl_s & scl_d_q & ~sda_d_q & sda_s;

	// ---------------------------------------------------------------
	// bus engine: address, pointer, data bytes with auto-increment
	// ---------------------------------------------------------------
	always @(posedge clock) begin
		if (srst) begin
			state_q   <= ST_IDLE;
			phase_q   <= PH_ADDR;
			bit_cnt_q <= 4'h0;
			shift_q   <= 8'h00;
			ptr_q     <= 8'h00;
			read_q    <= 1'b0;
			sda_oe_q  <= 1'b0;
			wr_q      <= 1'b0;
			wr_ptr_q  <= 8'h00;
			wr_data_q <= 8'h00;
		end else begin
			wr_q <= 1'b0;
			if (bus_start) begin
				// repeated start keeps the pointer for a following read
				state_q   <= ST_RX;
				phase_q   <= PH_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe_q  <= 1'b0;
			end else if (bus_stop) begin
				state_q  <= ST_IDLE;
				sda_oe_q <= 1'b0;
			end else begin
				case (state_q)
				ST_RX: begin
					if (scl_rise) begin
						shift_q   <= {shift_q[6:0], sda_s};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall && bit_cnt_q == 4'h8) begin
						bit_cnt_q <= 4'h0;
						case (phase_q)
						PH_ADDR: begin
							if (shift_q[7:1] == DEV_ADDR) begin
								read_q   <= shift_q[0];
								state_q  <= ST_ACK;
								sda_oe_q <= 1'b1;
							end else
								state_q <= ST_IDLE;
						end
						PH_PTR: begin
							ptr_q    <= shift_q;
							phase_q  <= PH_DATA;
							state_q  <= ST_ACK;
							sda_oe_q <= 1'b1;
						end
						default: begin
							// every byte is acknowledged, even when ignored
							wr_q      <= 1'b1;
							wr_ptr_q  <= ptr_q;
							wr_data_q <= shift_q;
							ptr_q     <= ptr_q + 8'h01;
							state_q   <= ST_ACK;
							sda_oe_q  <= 1'b1;
						end
						endcase
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						if (phase_q == PH_ADDR && read_q) begin
							state_q  <= ST_TX;
							shift_q  <= rd_data;
							ptr_q    <= ptr_q + 8'h01;
							sda_oe_q <= ~rd_data[7];
						end else begin
							if (phase_q == PH_ADDR)
								phase_q <= PH_PTR;
							state_q  <= ST_RX;
							sda_oe_q <= 1'b0;
						end
					end
				end
				ST_TX: begin
					if (scl_rise) begin
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_q == 4'h8) begin
							bit_cnt_q <= 4'h0;
							state_q   <= ST_RACK;
							sda_oe_q  <= 1'b0;
						end else begin
							shift_q  <= {shift_q[6:0], 1'b0};
							sda_oe_q <= ~shift_q[6];
						end
					end
				end
				ST_RACK: begin
					// a high acknowledge from the master ends the read
					if (scl_rise && sda_s) begin
						state_q <= ST_IDLE;
					end else if (scl_fall) begin
						state_q  <= ST_TX;
						shift_q  <= rd_data;
						ptr_q    <= ptr_q + 8'h01;
						sda_oe_q <= ~rd_data[7];
					end
				end
				default: begin // idle, or a stray code
					state_q  <= ST_IDLE;
					sda_oe_q <= 1'b0;
				end
				endcase
			end
		end
	end

	// open drain: only ever pulls low
	assign sda_out = 1'b0;
	assign sda_oe  = sda_oe_q;

	// ---------------------------------------------------------------
	// register writes, single-shot trigger and window status
	// ---------------------------------------------------------------
	assign lockable   = (wr_ptr_q >= `MCR_OFS_LOCK_FIRST) &&
	                    (wr_ptr_q <= `MCR_OFS_LOCK_LAST);
	assign soft_reset = wr_q && wr_ptr_q == `MCR_OFS_GENERAL_CONFIG &&
	                    wr_data_q[`MCR_GEN_SOFT_RESET];

	// the reset bit never stores, so it clears itself with the rest
	always @(posedge clock) begin
		if (srst || soft_reset) begin
			general_config_q        <= `MCR_RST_GENERAL;
			dac_output_config_q     <= `MCR_RST_DAC;
			gpio_pulldown_control_q <= `MCR_RST_GPIO;
			high_limit_irq_enable_q <= `MCR_RST_LIMIT_EN;
			low_limit_irq_enable_q  <= `MCR_RST_LIMIT_EN;
			channel_enable_low_q    <= `MCR_RST_CHAN_EN;
			channel_enable_high_q   <= `MCR_RST_CHAN_EN;
			temp_channel_enable_q   <= `MCR_RST_CHAN_EN;
		end else if (wr_q && !(lockable && register_lock)) begin
			case (wr_ptr_q)
			`MCR_OFS_GENERAL_CONFIG:
				general_config_q <= wr_data_q & `MCR_GEN_MASK;
			`MCR_OFS_DAC_CONFIG:
				dac_output_config_q <= wr_data_q & `MCR_DAC_MASK;
			`MCR_OFS_GPIO_PULLDOWN:
				gpio_pulldown_control_q <= wr_data_q;
			`MCR_OFS_HIGH_IRQ_EN:
				high_limit_irq_enable_q <= wr_data_q & `MCR_LIMIT_EN_MASK;
			`MCR_OFS_LOW_IRQ_EN:
				low_limit_irq_enable_q <= wr_data_q & `MCR_LIMIT_EN_MASK;
			`MCR_OFS_CHAN_EN_LOW:
				channel_enable_low_q <= wr_data_q;
			`MCR_OFS_CHAN_EN_HIGH:
				channel_enable_high_q <= wr_data_q;
			`MCR_OFS_TEMP_CHAN_EN:
				temp_channel_enable_q <= wr_data_q & `MCR_TEMP_EN_MASK;
			default: ;
			endcase
		end
	end

	// the trigger fires only while locked: the lock is what permits it
	always @(posedge clock) begin
		oneshot_fire <= !srst && wr_q &&
		                wr_ptr_q == `MCR_OFS_ONESHOT_TRIG &&
		                !general_config_q[`MCR_GEN_CONT_RUN] &&
		                register_lock;
	end

	// window status per monitored channel
	genvar ch;
	generate
		for (ch = 0; ch < MON; ch = ch + 1) begin : g_mon
			// status follows the latest result of its channel only
			always @(posedge clock) begin
				if (srst || soft_reset) begin
					over_limit_status_q[ch]  <= 1'b0;
					under_limit_status_q[ch] <= 1'b0;
				end else if (result_valid && result_sel == ch) begin
					over_limit_status_q[ch]  <= result_data >
						upper_threshold[ch*RW +: RW];
					under_limit_status_q[ch] <= result_data <=
						lower_threshold[ch*RW +: RW];
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// read mux and control outputs
	// ---------------------------------------------------------------
	always @* begin
		rd_data = 8'h00;
		case (ptr_q)
		`MCR_OFS_HIGH_STATUS:    rd_data[MON-1:0] = over_limit_status_q;
		`MCR_OFS_LOW_STATUS:     rd_data[MON-1:0] = under_limit_status_q;
		`MCR_OFS_GENERAL_CONFIG: rd_data = general_config_q;
		`MCR_OFS_DAC_CONFIG:     rd_data = dac_output_config_q;
		`MCR_OFS_GPIO_PULLDOWN:  rd_data = gpio_pulldown_control_q;
		`MCR_OFS_HIGH_IRQ_EN:    rd_data = high_limit_irq_enable_q;
		`MCR_OFS_LOW_IRQ_EN:     rd_data = low_limit_irq_enable_q;
		`MCR_OFS_CHAN_EN_LOW:    rd_data = channel_enable_low_q;
		`MCR_OFS_CHAN_EN_HIGH:   rd_data = channel_enable_high_q;
		`MCR_OFS_TEMP_CHAN_EN:   rd_data = temp_channel_enable_q;
		default:                 rd_data = 8'h00;
		endcase
	end

	// control outputs, all straight from the registers but continuous_run, which the lock gates
	assign register_lock       = general_config_q[`MCR_GEN_LOCK];
	assign bus_timeout_disable = general_config_q[`MCR_GEN_TIMEOUT_DIS];
	// continuous mode only runs once the bank is locked
	assign continuous_run = general_config_q[`MCR_GEN_CONT_RUN] &
	                        register_lock;
	// include bits are levels only; they never start anything
	assign input_include = {temp_channel_enable_q[0],
	                        channel_enable_high_q,
	                        channel_enable_low_q};
	assign output_grouping_select = dac_output_config_q[`MCR_DAC_GROUPING];
	assign forced_rail_select = dac_output_config_q[`MCR_DAC_RAIL_SEL];
	assign analog_outputs_hiz = dac_output_config_q[`MCR_DAC_HIZ];
	assign pulldown_off       = gpio_pulldown_control_q;

	// bit i of each enable register pairs with status bit i
	assign limit_irq_line_a = |(over_limit_status_q &
	                           high_limit_irq_enable_q[MON-1:0]);
	assign limit_irq_line_b = |(under_limit_status_q &
	                           low_limit_irq_enable_q[MON-1:0]);

endmodule // mcr_bank

// ===== rtl/mcr_regs.vh
// register offsets, field positions, reset values and codes of the
// monitor control register bank; included by the design files only
`ifndef MCR_REGS_VH
`define MCR_REGS_VH

// register offsets on the serial bus pointer
`define MCR_OFS_HIGH_STATUS     8'h12
`define MCR_OFS_LOW_STATUS      8'h13
`define MCR_OFS_GENERAL_CONFIG  8'h14
`define MCR_OFS_DAC_CONFIG      8'h15
`define MCR_OFS_GPIO_PULLDOWN   8'h16
`define MCR_OFS_HIGH_IRQ_EN     8'h17
`define MCR_OFS_LOW_IRQ_EN      8'h18
`define MCR_OFS_CHAN_EN_LOW     8'h19
`define MCR_OFS_CHAN_EN_HIGH    8'h1A
`define MCR_OFS_TEMP_CHAN_EN    8'h1B
`define MCR_OFS_ONESHOT_TRIG    8'h1C

// lockable window: from the high irq enable up to the trigger
`define MCR_OFS_LOCK_FIRST      8'h17
`define MCR_OFS_LOCK_LAST       8'h1C

// general configuration fields
`define MCR_GEN_SOFT_RESET      7
`define MCR_GEN_TIMEOUT_DIS     2
`define MCR_GEN_LOCK            1
`define MCR_GEN_CONT_RUN        0

// dac configuration fields
`define MCR_DAC_GROUPING        2
`define MCR_DAC_RAIL_SEL        1
`define MCR_DAC_HIZ             0

// implemented bits per register; reserved bits read zero
`define MCR_GEN_MASK            8'h07
`define MCR_DAC_MASK            8'h07
`define MCR_LIMIT_EN_MASK       8'h3F
`define MCR_TEMP_EN_MASK        8'h01

// power-on values
`define MCR_RST_GENERAL         8'h00
`define MCR_RST_DAC             8'h03
`define MCR_RST_GPIO            8'hFF
`define MCR_RST_LIMIT_EN        8'h00
`define MCR_RST_CHAN_EN         8'h00

// number of window-monitored channels and result width
`define MCR_MON_CHANNELS        6
`define MCR_RESULT_BITS         12

`endif

// ===== rtl/mcr_sync.v
// two-stage synchroniser for a group of pins from outside the clock
// domain; assumes nothing but the local clock and synchronous reset
`timescale 1ns/10ps

module mcr_sync #(
	parameter WIDTH = 2
) (
	// clock and reset
	input  wire             clock,
	input  wire             srst,
	// pins in, synchronised levels out
	input  wire [WIDTH-1:0] async_in,
	output wire [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] stable_q;

	// ---------------------------------------------------------------
	// per-bit double flop
	// ---------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			// idle bus level is high, so reset to one avoids a false start
			always @(posedge clock) begin
				if (srst) begin
					meta_q[i]   <= 1'b1;
					stable_q[i] <= 1'b1;
				end else begin
					meta_q[i]   <= async_in[i];
					stable_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate

	assign sync_out = stable_q;

endmodule // mcr_sync

// ===== tb/mcr_bank_asserts.sv
// port-level checker of the monitor control register bank
// assumes one core clock domain and the bind at the foot
`timescale 1ns/10ps

module mcr_bank_asserts #(
	parameter MON = 6,
	parameter RW  = 12
) (
	// clock and reset
	input wire                clock,
	input wire                srst,
	// bus pins
	input wire                scl_in,
	input wire                sda_in,
	input wire                sda_out,
	input wire                sda_oe,
	// results
	input wire                result_valid,
	input wire [2:0]          result_sel,
	input wire [RW-1:0]       result_data,
	input wire [MON*RW-1:0]   upper_threshold,
	input wire [MON*RW-1:0]   lower_threshold,
	// control outputs
	input wire                continuous_run,
	input wire                oneshot_fire,
	input wire [16:0]         input_include,
	input wire                bus_timeout_disable,
	input wire                register_lock,
	input wire                output_grouping_select,
	input wire                forced_rail_select,
	input wire                analog_outputs_hiz,
	input wire [7:0]          pulldown_off,
	input wire                limit_irq_line_a,
	input wire                limit_irq_line_b
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	// ------------------------------------------------------------
	// conversion start
	// ------------------------------------------------------------
	sequence s_fire;
		oneshot_fire ##1 !oneshot_fire;
	endsequence
	property p_fire_pulse;
		oneshot_fire |-> s_fire;
	endproperty
	a_fire_pulse: assert property (p_fire_pulse)
		else $error("trigger pulse too long");
	property p_fire_lock;
		oneshot_fire |-> register_lock;
	endproperty
	a_fire_lock: assert property (p_fire_lock)
		else $error("trigger while unlocked");
	property p_fire_idle;
		oneshot_fire |-> !continuous_run;
	endproperty
	a_fire_idle: assert property (p_fire_idle)
		else $error("trigger in continuous mode");
	property p_cont_lock;
		continuous_run |-> register_lock;
	endproperty
	a_cont_lock: assert property (p_cont_lock)
		else $error("continuous run while unlocked");
	// open drain: the device may only ever pull the data line low
	property p_sda_low;
		sda_oe |-> !sda_out;
	endproperty
	a_sda_low: assert property (p_sda_low)
		else $error("data line driven high");

	// ------------------------------------------------------------
	// reset and lock
	// ------------------------------------------------------------
	property p_reset_vals;
		$fell(srst) |-> analog_outputs_hiz && forced_rail_select
			&& !output_grouping_select && pulldown_off == 8'hFF
			&& input_include == 17'h0_0000 && !register_lock
			&& !limit_irq_line_a && !limit_irq_line_b;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("wrong value after reset");
	// a locked enable set may only move when the lock drops too
	property p_lock_hold;
		register_lock && $past(register_lock) |-> $stable(input_include);
	endproperty
	a_lock_hold: assert property (p_lock_hold)
		else $error("locked enable changed");

	// ------------------------------------------------------------
	// interrupt lines: under lock only a result may raise line a or drop line b
	// ------------------------------------------------------------
	property p_irq_rise;
		$rose(limit_irq_line_a) && register_lock |-> $past(result_valid);
	endproperty
	a_irq_rise: assert property (p_irq_rise)
		else $error("over line rose without result");
	property p_irq_fall;
		$fell(limit_irq_line_b) && register_lock |-> $past(result_valid);
	endproperty
	a_irq_fall: assert property (p_irq_fall)
		else $error("under line fell without result");
endmodule // mcr_bank_asserts

bind mcr_bank mcr_bank_asserts #(.MON(MON), .RW(RW)) i_mcr_bank_asserts (
	.clock(clock), .srst(srst), .scl_in(scl_in), .sda_in(sda_in),
	.sda_out(sda_out), .sda_oe(sda_oe), .result_valid(result_valid),
	.result_sel(result_sel), .result_data(result_data),
	.upper_threshold(upper_threshold), .lower_threshold(lower_threshold),
	.continuous_run(continuous_run), .oneshot_fire(oneshot_fire),
	.input_include(input_include), .register_lock(register_lock),
	.bus_timeout_disable(bus_timeout_disable),
	.output_grouping_select(output_grouping_select),
	.forced_rail_select(forced_rail_select),
	.analog_outputs_hiz(analog_outputs_hiz), .pulldown_off(pulldown_off),
	.limit_irq_line_a(limit_irq_line_a), .limit_irq_line_b(limit_irq_line_b)
);

// ===== tb/mcr_host.sv
// bus master model: drives the serial clock and pulls the data line
// assumes an external pull-up forms the data line level
`timescale 1ns/10ps

module mcr_host (
	// clock
	input wire      clock,
	// bus
	input wire      sda_line,
	output reg      scl_pin,
	output reg      sda_pull
);
	int hp = 4; // half bit in core clocks; larger means a slow master

	initial begin
		scl_pin = 1'b1;
		sda_pull = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask

	// data moves mid-low, sampled mid-high, clock idles high
	task automatic put_bit(input logic b, output logic r);
		scl_pin <= 1'b0;
		tick(hp / 2);
		sda_pull <= ~b;
		tick(hp - hp / 2);
		scl_pin <= 1'b1;
		tick(hp / 2);
		r = sda_line;
		tick(hp - hp / 2);
	endtask

	task automatic start_c;
		scl_pin <= 1'b0;
		tick(hp / 2);
		sda_pull <= 1'b0;
		tick(hp - hp / 2);
		scl_pin <= 1'b1;
		tick(hp);
		sda_pull <= 1'b1;
		tick(hp);
	endtask

	task automatic stop_c;
		scl_pin <= 1'b0;
		tick(hp / 2);
		sda_pull <= 1'b1;
		tick(hp - hp / 2);
		scl_pin <= 1'b1;
		tick(hp);
		sda_pull <= 1'b0;
		tick(hp);
	endtask

	task automatic xbyte(input [7:0] d, input logic ab,
		output [7:0] q, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			put_bit(d[i], q[i]);
		end
		put_bit(ab, ack);
	endtask
endmodule // mcr_host

// ===== tb/testbench.sv
// self-checking bench of the monitor control register bank
// assumes the host model drives the bus; pull-up on the data line
`timescale 1ns/10ps

`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_count++; \
	$display("unexpected at %0t got %h expected %h", $time, g, e); end end

module testbench;
	localparam [6:0] DEV = 7'h2A; // arbitrary bus address
	reg          clock, srst, result_valid;
	reg  [2:0]   result_sel;
	reg  [11:0]  result_data;
	wire         sda_oe, scl_pin, sda_pull, cont, fire, lock, btd;
	wire         grp, rail, hiz, irq_a, irq_b;
	wire [16:0]  incl;
	wire [7:0]   pd;
	wire         sda_line = !(sda_oe | sda_pull);
	int          err_count = 0, checked = 0, fires = 0;
	reg  [7:0]   v, q;
	reg          a;
	reg  [7:0]   dflt [0:8] = '{8'h00, 8'h03, 8'hFF, 0, 0, 0, 0, 0, 0};
	reg  [7:0]   fmask [0:8] = '{0, 8'h07, 8'hFF, 8'h3F, 8'h3F, 8'hFF,
		8'hFF, 8'h01, 0};

	mcr_bank #(.DEV_ADDR(DEV)) i_mcr_bank (.clock(clock), .srst(srst),
		.scl_in(scl_pin), .sda_in(sda_line), .sda_out(), .sda_oe(sda_oe),
		.result_valid(result_valid), .result_sel(result_sel),
		.result_data(result_data), .upper_threshold({6{12'h800}}),
		.lower_threshold({6{12'h100}}), .continuous_run(cont),
		.oneshot_fire(fire), .input_include(incl),
		.bus_timeout_disable(btd), .register_lock(lock),
		.output_grouping_select(grp), .forced_rail_select(rail),
		.analog_outputs_hiz(hiz), .pulldown_off(pd),
		.limit_irq_line_a(irq_a), .limit_irq_line_b(irq_b));
	mcr_host i_mcr_host (.clock(clock), .sda_line(sda_line),
		.scl_pin(scl_pin), .sda_pull(sda_pull));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// count trigger pulses on the sequencer side
	always @(posedge clock) begin
		if (fire === 1'b1) fires++;
	end

	task tally_and_finish;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// one byte to the device, which must acknowledge it
	task send(input [7:0] d);
		i_mcr_host.xbyte(d, 1'b1, q, a);
		`CHK(a, 1'b0)
	endtask

	task wr(input [7:0] p, input [7:0] d);
		i_mcr_host.start_c();
		send({DEV, 1'b0});
		send(p);
		send(d);
		i_mcr_host.stop_c();
	endtask

	// pointer write, repeated start, one byte read and refused
	task rchk(input [7:0] p, input [7:0] e);
		i_mcr_host.start_c();
		send({DEV, 1'b0});
		send(p);
		i_mcr_host.start_c();
		send({DEV, 1'b1});
		i_mcr_host.xbyte(8'hFF, 1'b1, v, a);
		i_mcr_host.stop_c();
		`CHK(v, e)
	endtask

	task res(input [2:0] s, input [11:0] d);
		result_sel <= s;
		result_data <= d;
		result_valid <= 1'b1;
		@(posedge clock);
		result_valid <= 1'b0;
		repeat (2) @(posedge clock);
	endtask

	initial begin
		repeat (100000) @(posedge clock);
		err_count++;
		tally_and_finish;
	end

	initial begin
		srst = 1'b1;
		result_valid = 1'b0;
		result_sel = 3'h0;
		result_data = 12'h000;
		repeat (8) @(posedge clock);
		srst <= 1'b0;
		repeat (4) @(posedge clock);
		// power-on values, then all ones with reserved bits dropped
		for (int i = 0; i < 9; i++) rchk(8'h14 + i, dflt[i]);
		`CHK({grp, rail, hiz, pd}, {3'b011, 8'hFF})
		for (int i = 1; i < 8; i++) wr(8'h14 + i, 8'hFF);
		for (int i = 1; i < 9; i++) rchk(8'h14 + i, fmask[i]);
		`CHK({incl, grp, rail, hiz}, 20'hF_FFFF)
		`CHK(fires, 0)
		for (int i = 1; i < 8; i++) wr(8'h14 + i, 8'h00);
		`CHK({incl, grp, rail, hiz, pd}, 28'h000_0000)
		wr(8'h70, 8'h55);
		rchk(8'h70, 8'h00);
		// a foreign address is left unanswered
		i_mcr_host.start_c();
		i_mcr_host.xbyte({~DEV, 1'b0}, 1'b1, q, a);
		i_mcr_host.stop_c();
		`CHK(a, 1'b1)
		// single shot needs the lock and an idle continuous mode
		wr(8'h1C, 8'h00);
		`CHK(fires, 0)
		wr(8'h19, 8'h0F);
		wr(8'h14, 8'h02);
		wr(8'h1C, 8'hA5);
		`CHK({fires[1:0], lock, btd}, 4'b0110)
		wr(8'h19, 8'hF0);
		rchk(8'h19, 8'h0F);
		wr(8'h14, 8'h07);
		`CHK({cont, btd}, 2'b11)
		wr(8'h1C, 8'h01);
		`CHK(fires, 1)
		wr(8'h14, 8'h06);
		`CHK(cont, 1'b0)
		wr(8'h14, 8'h01);
		`CHK(cont, 1'b0)
		// each enable bit unmasks only its own channel
		for (int i = 0; i < 6; i++) begin
			wr(8'h17, 8'h01 << i);
			wr(8'h18, 8'h01 << i);
			res(i, 12'h801);
			`CHK(irq_a, 1'b1)
			rchk(8'h12, 8'h01 << i);
			res((i + 1) % 6, 12'h801);
			res(i, 12'h800);
			`CHK(irq_a, 1'b0)
			res(i, 12'h100);
			`CHK(irq_b, 1'b1)
			res((i + 1) % 6, 12'h100);
			res(i, 12'h101);
			`CHK(irq_b, 1'b0)
		end
		// locked: lines still follow the results
		wr(8'h14, 8'h02);
		res(5, 12'hFFF);
		res(5, 12'h000);
		`CHK({irq_a, irq_b}, 2'b01)
		res(5, 12'h200);
		`CHK(irq_b, 1'b0)
		// soft reset restores the power-on values, itself included
		wr(8'h14, 8'h80);
		`CHK({lock, cont, irq_a, hiz, rail, pd, incl}, 30'h07FE_0000)
		rchk(8'h14, 8'h00);
		rchk(8'h19, 8'h00);
		// a slow master must be served the same way
		i_mcr_host.hp = 8;
		wr(8'h16, 8'h5A);
		`CHK(pd, 8'h5A)
		tally_and_finish;
	end
endmodule // testbench
